// file: verilog/usb_txn_pkg.sv
`default_nettype none

package usb_txn_pkg;

  // Serializer timing: one bus bit every ten system clock cycles
  localparam int BIT_CYCLES = 10;
  localparam int BIT_HALF = BIT_CYCLES / 2;

  // Bit counts within a packet
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] HSK_BITS = 8'h08;
  localparam logic [1:0] EOP_SE0_BITS = 2'h2;
  localparam logic [1:0] EOP_LAST = 2'h3;
  localparam logic [7:0] RX_WAIT_BITS = 8'h10;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TOKEN_LEN = 8'h01;
  localparam logic [7:0] REG_DATA_LEN = 8'h02;
  localparam logic [7:0] REG_HSK_RESULT = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [1:0] BUF_REGION = 2'h1;

  // Buffer indices inside the shared buffer array
  localparam logic [5:0] TOKEN_BASE = 6'h00;
  localparam logic [5:0] DATA_BASE = 6'h20;

  // Control and status fields
  localparam int CTRL_START = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_ENC = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_PEER_END = 2;
  localparam int STAT_TIMEOUT = 3;

  // Output word layout and fixed words
  localparam int PORT_TX = 0;
  localparam logic [3:0] WORD_RELEASE = 4'h0;
  localparam logic [3:0] WORD_SE0 = 4'hE;
  localparam logic [3:0] WORD_IDLE_J = 4'h6;
  localparam logic [7:0] LEN_RESET = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE, S_TX_SYNC, S_TX_BODY, S_TX_EOP, S_RX_WAIT, S_RX_SYNC, S_RX_BITS
  } state_t;

  typedef enum logic [1:0] {ph_token, ph_data, ph_ack, ph_hsk} phase_t;

endpackage

`default_nettype wire

// file: verilog/usb_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none

module usb_bit_timer #(
  parameter int PERIOD = usb_txn_pkg::BIT_CYCLES
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic align_i,
  output logic tick_o
);

  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  localparam logic [CW-1:0] HALF = CW'(PERIOD / 2 - 1);

  logic [CW-1:0] count;

  // Realign to mid-bit on a receive edge, else free run while active
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      count <= '0;
    else if (ce_i)
    begin
      if (!run_i)
        count <= LAST;
      else if (align_i)
        count <= HALF;
      else if (count == '0)
        count <= LAST;
      else
        count <= count - 1'b1;
    end
  end

  assign tick_o = ce_i && run_i && !align_i && (count == '0);

endmodule

`default_nettype wire

// file: verilog/usb_txn_engine.sv
// Behaviour
// - Handshake after host data is stored as one byte, first bit in MSB.
// - Direction setting selects transmit or receive for the data stage.
// - Encoding indicator is stored for software only, never used.
// - Transaction opens with sync, token bits, end-of-packet.
// - Data receive releases bus, waits sync, then captures bits.
// - SE0 ends reception; then check whether packet was a handshake.
// - Data transmit sends sync, data bits, end-of-packet like token.
// - After host data, wait for sync and record one handshake byte.
// - After received data of other than eight bits send sync, ACK byte, end-of-packet.
// - Handshake instead of data ends transaction with no host handshake.
// - One bus bit every ten clock cycles during transmission.
// - Bytes fetched from consecutive addresses, MSB first, every 8 bits.
// - Word: bit0 transmit, bits1-2 drive enable, bit3 SE0 enable.
// - Bit counter loaded with length, decremented per bit, stops at zero.
// - Drive enable stays set for every bit of a transmitted packet.
// - Received stuffed bits are stored and counted as plain bits.
// - Receive adds received bits to data length, fills bytes MSB first.
// - Token and transmit data lengths count down to zero.
`timescale 1ns/1ps
`default_nettype none

module usb_txn_engine #(
  parameter int BUF_BYTES = 32,
  parameter logic [7:0] SYNC_PATTERN = 8'h54,
  parameter logic [7:0] ACK_PATTERN = 8'hD7
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic dplus_i,
  input wire logic dminus_i,
  output logic [3:0] bus_output_port_o
);

  localparam int AW = $clog2(2 * BUF_BYTES);

  usb_txn_pkg::state_t st;
  usb_txn_pkg::phase_t phase;
  logic [7:0] buf_mem [2*BUF_BYTES];
  logic [1:0] dp_meta, dm_meta;
  logic dp, dm, k_line, se0_line, tick, prev_k;
  logic dir_rx, enc_flag, done, peer_end, timeout;
  logic [7:0] tok_len, data_len, hsk, shift, shift_in, rx_bits, wait_cnt;
  logic [7:0] cur_len, rx_word;
  logic [3:0] cnt;
  logic [2:0] bitpos;
  logic [1:0] eop_cnt;
  logic [AW-1:0] ptr;
  logic start, idle, rx_we;

  function automatic logic is_buf(input logic [7:0] a);
    return a[7:6] == usb_txn_pkg::BUF_REGION;
  endfunction

  assign idle = (st == usb_txn_pkg::S_IDLE);
  assign start = wr_i && idle && (addr_i == usb_txn_pkg::REG_CTRL)
    && wdata_i[usb_txn_pkg::CTRL_START];
  assign k_line = dp && !dm;
  assign se0_line = !dp && !dm;
  assign cur_len = (phase == usb_txn_pkg::ph_token) ? tok_len : data_len;
  // Received byte write, partial last byte left aligned
  assign rx_we = tick && (st == usb_txn_pkg::S_RX_BITS)
    && (phase == usb_txn_pkg::ph_data)
    && (se0_line ? (bitpos != 3'h0) : (bitpos == 3'h7));
  assign rx_word = se0_line ? (shift_in << (4'h8 - {1'b0, bitpos}))
    : {shift_in[6:0], dp};

  usb_bit_timer #(.PERIOD(usb_txn_pkg::BIT_CYCLES)) u_timer (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .run_i(!idle),
    .align_i((st == usb_txn_pkg::S_RX_WAIT) && k_line),
    .tick_o(tick)
  );

  // Line inputs cross into the clock domain
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dp_meta <= 2'h0;
      // Idle line is J with D- high, so no false SE0 follows reset
      dm_meta <= 2'h3;
    end
    else if (ce_i)
    begin
      dp_meta <= {dp_meta[0], dplus_i};
      dm_meta <= {dm_meta[0], dminus_i};
    end
  end
  assign dp = dp_meta[1];
  assign dm = dm_meta[1];

  // Software settings; encoding flag kept for readback only
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dir_rx <= 1'b0;
      enc_flag <= 1'b0;
    end
    else if (ce_i && wr_i && idle && addr_i == usb_txn_pkg::REG_CTRL)
    begin
      dir_rx <= wdata_i[usb_txn_pkg::CTRL_DIR];
      enc_flag <= wdata_i[usb_txn_pkg::CTRL_ENC];
    end
  end

  // Buffer array: software writes while idle, engine writes received bytes
  always_ff @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (rx_we)
        buf_mem[ptr] <= rx_word;
      else if (wr_i && idle && is_buf(addr_i))
        buf_mem[addr_i[AW-1:0]] <= wdata_i;
    end
  end

  // Read data valid in the cycle after the strobe
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else if (ce_i)
    begin
      if (!rd_i)
        rdata_o <= 8'h00;
      else if (is_buf(addr_i))
        rdata_o <= buf_mem[addr_i[AW-1:0]];
      else
        unique case (addr_i)
          usb_txn_pkg::REG_CTRL: rdata_o <= {5'h00, enc_flag, dir_rx, 1'b0};
          usb_txn_pkg::REG_TOKEN_LEN: rdata_o <= tok_len;
          usb_txn_pkg::REG_DATA_LEN: rdata_o <= data_len;
          usb_txn_pkg::REG_HSK_RESULT: rdata_o <= hsk;
          usb_txn_pkg::REG_STATUS:
            rdata_o <= {4'h0, timeout, peer_end, done, !idle};
          default: rdata_o <= 8'h00;
        endcase
    end
  end

  // Transaction sequencer
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st <= usb_txn_pkg::S_IDLE;
      phase <= usb_txn_pkg::ph_token;
      bus_output_port_o <= usb_txn_pkg::WORD_RELEASE;
      tok_len <= usb_txn_pkg::LEN_RESET;
      data_len <= usb_txn_pkg::LEN_RESET;
      hsk <= 8'h00;
      shift <= 8'h00;
      shift_in <= 8'h00;
      rx_bits <= 8'h00;
      wait_cnt <= 8'h00;
      cnt <= 4'h0;
      bitpos <= 3'h0;
      eop_cnt <= 2'h0;
      ptr <= '0;
      prev_k <= 1'b0;
      done <= 1'b0;
      peer_end <= 1'b0;
      timeout <= 1'b0;
    end
    else if (ce_i)
    begin
      if (idle)
      begin
        if (wr_i && addr_i == usb_txn_pkg::REG_TOKEN_LEN)
          tok_len <= wdata_i;
        if (wr_i && addr_i == usb_txn_pkg::REG_DATA_LEN)
          data_len <= wdata_i;
        if (start)
        begin
          st <= usb_txn_pkg::S_TX_SYNC;
          phase <= usb_txn_pkg::ph_token;
          shift <= SYNC_PATTERN;
          cnt <= usb_txn_pkg::BYTE_BITS;
          ptr <= AW'(usb_txn_pkg::TOKEN_BASE);
          hsk <= 8'h00;
          done <= 1'b0;
          peer_end <= 1'b0;
          timeout <= 1'b0;
        end
      end
      else if (tick)
      begin
        unique case (st)
          usb_txn_pkg::S_TX_SYNC:
          begin
            bus_output_port_o <= {3'b011, shift[7]};
            shift <= shift << 1;
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1)
            begin
              eop_cnt <= 2'h0;
              bitpos <= 3'h0;
              if (phase == usb_txn_pkg::ph_ack)
              begin
                shift <= ACK_PATTERN;
                cnt <= usb_txn_pkg::BYTE_BITS;
                st <= usb_txn_pkg::S_TX_BODY;
              end
              else if (cur_len == 8'h00)
                st <= usb_txn_pkg::S_TX_EOP;
              else
              begin
                shift <= buf_mem[ptr];
                ptr <= ptr + 1'b1;
                st <= usb_txn_pkg::S_TX_BODY;
              end
            end
          end
          usb_txn_pkg::S_TX_BODY:
          begin
            bus_output_port_o <= {3'b011, shift[7]};
            shift <= shift << 1;
            if (phase == usb_txn_pkg::ph_ack)
            begin
              cnt <= cnt - 4'h1;
              if (cnt == 4'h1)
                st <= usb_txn_pkg::S_TX_EOP;
            end
            else
            begin
              if (phase == usb_txn_pkg::ph_token)
                tok_len <= tok_len - 8'h01;
              else
                data_len <= data_len - 8'h01;
              bitpos <= bitpos + 3'h1;
              if (bitpos == 3'h7)
              begin
                shift <= buf_mem[ptr];
                ptr <= ptr + 1'b1;
              end
              if (cur_len == 8'h01)
                st <= usb_txn_pkg::S_TX_EOP;
            end
          end
          usb_txn_pkg::S_TX_EOP:
          begin
            eop_cnt <= eop_cnt + 2'h1;
            if (eop_cnt < usb_txn_pkg::EOP_SE0_BITS)
              bus_output_port_o <= usb_txn_pkg::WORD_SE0;
            else if (eop_cnt == usb_txn_pkg::EOP_SE0_BITS)
              bus_output_port_o <= usb_txn_pkg::WORD_IDLE_J;
            else
            begin
              bus_output_port_o <= usb_txn_pkg::WORD_RELEASE;
              wait_cnt <= 8'h00;
              rx_bits <= 8'h00;
              bitpos <= 3'h0;
              unique case (phase)
                usb_txn_pkg::ph_token:
                begin
                  phase <= usb_txn_pkg::ph_data;
                  if (dir_rx)
                  begin
                    st <= usb_txn_pkg::S_RX_WAIT;
                    ptr <= AW'(usb_txn_pkg::DATA_BASE);
                  end
                  else
                  begin
                    st <= usb_txn_pkg::S_TX_SYNC;
                    shift <= SYNC_PATTERN;
                    cnt <= usb_txn_pkg::BYTE_BITS;
                    ptr <= AW'(usb_txn_pkg::DATA_BASE);
                  end
                end
                usb_txn_pkg::ph_data:
                begin
                  phase <= usb_txn_pkg::ph_hsk;
                  st <= usb_txn_pkg::S_RX_WAIT;
                end
                usb_txn_pkg::ph_ack, usb_txn_pkg::ph_hsk:
                begin
                  st <= usb_txn_pkg::S_IDLE;
                  done <= 1'b1;
                end
              endcase
            end
          end
          usb_txn_pkg::S_RX_WAIT:
          begin
            wait_cnt <= wait_cnt + 8'h01;
            if (wait_cnt == usb_txn_pkg::RX_WAIT_BITS - 8'h01)
            begin
              st <= usb_txn_pkg::S_IDLE;
              timeout <= 1'b1;
              done <= 1'b1;
            end
          end
          usb_txn_pkg::S_RX_SYNC:
          begin
            prev_k <= k_line;
            if (k_line && prev_k)
              st <= usb_txn_pkg::S_RX_BITS;
          end
          usb_txn_pkg::S_RX_BITS:
          begin
            if (se0_line)
            begin
              if (phase == usb_txn_pkg::ph_hsk)
              begin
                st <= usb_txn_pkg::S_IDLE;
                done <= 1'b1;
              end
              else if (rx_bits == usb_txn_pkg::HSK_BITS)
              begin
                st <= usb_txn_pkg::S_IDLE;
                peer_end <= 1'b1;
                done <= 1'b1;
              end
              else
              begin
                phase <= usb_txn_pkg::ph_ack;
                st <= usb_txn_pkg::S_TX_SYNC;
                shift <= SYNC_PATTERN;
                cnt <= usb_txn_pkg::BYTE_BITS;
              end
            end
            else
            begin
              rx_bits <= rx_bits + 8'h01;
              shift_in <= {shift_in[6:0], dp};
              bitpos <= bitpos + 3'h1;
              if (phase == usb_txn_pkg::ph_data)
              begin
                data_len <= data_len + 8'h01;
                if (bitpos == 3'h7)
                  ptr <= ptr + 1'b1;
              end
              else if (rx_bits < usb_txn_pkg::HSK_BITS)
                hsk <= {hsk[6:0], dp};
            end
          end
          default: st <= usb_txn_pkg::S_IDLE;
        endcase
      end
      else if (st == usb_txn_pkg::S_RX_WAIT && k_line)
      begin
        st <= usb_txn_pkg::S_RX_SYNC;
        prev_k <= 1'b0;
      end
    end
  end

  AST_TOKEN_FIRST: assert property (@(posedge clock_i) disable iff (!rstn_i)
    start && ce_i |=> st == usb_txn_pkg::S_TX_SYNC
      && phase == usb_txn_pkg::ph_token)
    else $error("transaction did not open with token sync");

  AST_BIT_PERIOD: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tick && ce_i && st == usb_txn_pkg::S_TX_BODY && cur_len > 8'h01
      && phase != usb_txn_pkg::ph_ack
    |=> (!tick)[*8] ##1 !tick ##1 tick)
    else $error("transmit bit spacing is not ten cycles");

  AST_EN_HELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st == usb_txn_pkg::S_TX_BODY |-> bus_output_port_o[2:1] == 2'b11
      && !bus_output_port_o[3])
    else $error("drive enable dropped inside a packet");

  AST_LEN_DEC: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tick && ce_i && st == usb_txn_pkg::S_TX_BODY
      && phase == usb_txn_pkg::ph_token
    |=> tok_len == $past(tok_len) - 8'h01)
    else $error("token length not decremented per bit");

  AST_BYTE_FETCH: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tick && ce_i && st == usb_txn_pkg::S_TX_BODY && bitpos == 3'h7
      && phase != usb_txn_pkg::ph_ack
    |=> ptr == $past(ptr) + 1'b1)
    else $error("next byte not fetched after eight bits");

  AST_EOP_SE0: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tick && ce_i && st == usb_txn_pkg::S_TX_EOP && eop_cnt == 2'h0
    |=> bus_output_port_o == usb_txn_pkg::WORD_SE0)
    else $error("end-of-packet did not drive SE0");

  AST_RX_RELEASE: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st == usb_txn_pkg::S_RX_WAIT || st == usb_txn_pkg::S_RX_BITS
    |-> bus_output_port_o == usb_txn_pkg::WORD_RELEASE)
    else $error("bus driven while receiving");

  AST_RX_LEN_INC: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tick && ce_i && st == usb_txn_pkg::S_RX_BITS && !se0_line
      && phase == usb_txn_pkg::ph_data
    |=> data_len == $past(data_len) + 8'h01)
    else $error("data length not increased per received bit");

  AST_ACK_AFTER_RX: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tick && ce_i && st == usb_txn_pkg::S_RX_BITS && se0_line
      && phase == usb_txn_pkg::ph_data && rx_bits != usb_txn_pkg::HSK_BITS
    |=> st == usb_txn_pkg::S_TX_SYNC && phase == usb_txn_pkg::ph_ack)
    else $error("no ACK after received data");

  AST_PEER_END: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(peer_end) |-> idle && done)
    else $error("host continued after peer handshake");

  AST_DIR_RX: assert property (@(posedge clock_i) disable iff (!rstn_i)
    tick && ce_i && st == usb_txn_pkg::S_TX_EOP && eop_cnt == 2'h3
      && phase == usb_txn_pkg::ph_token && dir_rx
    |=> st == usb_txn_pkg::S_RX_WAIT)
    else $error("receive direction did not release for data");

  COV_TX_DONE: cover property (@(posedge clock_i) disable iff (!rstn_i)
    phase == usb_txn_pkg::ph_hsk && $rose(done));
  COV_RX_ACK: cover property (@(posedge clock_i) disable iff (!rstn_i)
    phase == usb_txn_pkg::ph_ack && st == usb_txn_pkg::S_TX_BODY);
  COV_PEER_END: cover property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(peer_end));

endmodule

`default_nettype wire

// file: verification/usb_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

module usb_peer_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [3:0] port_i,
  input wire logic arm_i,
  input wire logic [1:0] nrel_i,
  input wire logic [7:0] gap_i,
  input wire logic [7:0] nbits_i,
  input wire logic [255:0] bits_i,
  output logic dplus_o,
  output logic dminus_o
);
  logic drv;
  logic pd;
  logic pm;
  logic host_on;
  logic prev_en;
  int rel;

  // Host drive wins; a released bus is pulled to idle J
  assign host_on = port_i[1] | port_i[2];
  assign dplus_o = host_on ? (port_i[0] & ~port_i[3]) : (drv ? pd : 1'b0);
  assign dminus_o = host_on ? (~port_i[0] & ~port_i[3]) : (drv ? pm : 1'b1);

  task automatic send(input logic p, input logic m);
    pd <= p;
    pm <= m;
    repeat (10) @(posedge clock_i);
  endtask

  initial
  begin
    drv = 1'b0;
    pd = 1'b0;
    pm = 1'b1;
    forever
    begin
      @(posedge clock_i);
      if (arm_i && rstn_i)
      begin
        rel = 0;
        prev_en = host_on;
        // Answer only after the host released the bus nrel_i times
        while (rel < int'(nrel_i))
        begin
          @(posedge clock_i);
          if (prev_en && !host_on)
            rel = rel + 1;
          prev_en = host_on;
        end
        repeat (int'(gap_i) * 10) @(posedge clock_i);
        drv <= 1'b1;
        for (int i = 0; i < 8; i++)
          send(i % 2 == 0 || i == 7, !(i % 2 == 0 || i == 7));
        for (int i = 0; i < int'(nbits_i); i++)
          send(bits_i[255 - i], !bits_i[255 - i]);
        send(1'b0, 1'b0);
        send(1'b0, 1'b0);
        send(1'b0, 1'b1);
        drv <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// file: verification/test_low_speed_usb_host_transaction_engine.sv
`timescale 1ns/1ps
`default_nettype none

module test_low_speed_usb_host_transaction_engine;
  localparam logic [7:0] SYNC = 8'h54;
  localparam logic [7:0] ACK = 8'hD7;
  logic clock_i, rstn_i, ce_i, wr_i, rd_i, arm, dp, dm;
  logic [7:0] addr_i, wdata_i, rdata_o, gap, nbits;
  logic [3:0] port;
  logic [1:0] nrel;
  logic [255:0] pbits;
  logic [3:0] words[$];
  int err_total, num_checks, seed;

  usb_txn_engine #(.SYNC_PATTERN(SYNC), .ACK_PATTERN(ACK)) dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .dplus_i(dp), .dminus_i(dm), .bus_output_port_o(port));

  usb_peer_model peer_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .port_i(port), .arm_i(arm),
    .nrel_i(nrel), .gap_i(gap), .nbits_i(nbits), .bits_i(pbits),
    .dplus_o(dp), .dminus_o(dm));

  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic complete_run();
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  function automatic logic [7:0] exp_status(input int kind);
    case (kind)
      2: return 8'h06;
      3: return 8'h0A;
      default: return 8'h02;
    endcase
  endfunction

  function automatic logic [7:0] mask(input int n);
    return (n >= 8) ? 8'hFF : ~(8'hFF >> n);
  endfunction

  // Records one host packet, one word per bit slot, up to its release
  task automatic capture();
    logic [3:0] w;
    int t;
    words.delete();
    t = 0;
    while (port[1] !== 1'b1)
    begin
      @(posedge clock_i);
      #1;
      t++;
      if (t > 1200)
      begin
        err_total++;
        complete_run();
      end
    end
    while (words.size() < 300)
    begin
      w = port;
      repeat (9)
      begin
        @(posedge clock_i);
        #1;
        chk("hold", {4'h0, w}, {4'h0, port});
      end
      @(posedge clock_i);
      #1;
      words.push_back(w);
      if (w == 4'h6 && words.size() > 2 && words[$-1] == 4'hE
          && words[$-2] == 4'hE)
        break;
    end
    chk("release", 8'h00, {4'h0, port});
  endtask

  task automatic check_pkt(input logic [255:0] b, input int len);
    logic [263:0] s;
    s = {SYNC, b};
    chk("count", 8'(len), 8'(words.size() - 11));
    if (words.size() == len + 11)
      for (int i = 0; i < len + 11; i++)
        chk("word", (i < len + 8) ? {7'h03, s[263 - i]}
          : (i < len + 10 ? 8'h0E : 8'h06), {4'h0, words[i]});
  endtask

  task automatic wait_idle();
    logic [7:0] d;
    int t;
    t = 0;
    d = 8'h01;
    while (d[0] !== 1'b0 && t < 1000)
    begin
      rd(usb_txn_pkg::REG_STATUS, d);
      t++;
    end
    if (t >= 1000)
    begin
      err_total++;
      complete_run();
    end
  endtask

  // Kinds: 0 data out, 1 data in, 2 handshake in place of data, 3 silence
  task automatic run_txn(input int kind, input int tlen);
    logic [255:0] tb, db, pb;
    logic [7:0] d, init, m;
    logic enc;
    int dlen, plen;
    for (int i = 0; i < 8; i++)
    begin
      tb[32*i +: 32] = $random(seed);
      db[32*i +: 32] = $random(seed);
      pb[32*i +: 32] = $random(seed);
    end
    if (kind == 1)
      pb[255:249] = 7'h7F;
    init = 8'($random(seed) & 63);
    dlen = (kind == 0) ? ($random(seed) & 63) : 0;
    plen = (kind == 1) ? 9 + ($random(seed) & 31) : 8;
    enc = 1'($random(seed));
    for (int i = 0; i < 32; i++)
    begin
      bus_wr(8'h40 + 8'(i), tb[255 - 8*i -: 8]);
      bus_wr(8'h60 + 8'(i), db[255 - 8*i -: 8]);
    end
    bus_wr(usb_txn_pkg::REG_TOKEN_LEN, 8'(tlen));
    bus_wr(usb_txn_pkg::REG_DATA_LEN, (kind == 1) ? init : 8'(dlen));
    if (kind < 3)
    begin
      pbits <= pb;
      nbits <= 8'(plen);
      gap <= 8'(1 + ($random(seed) & 7));
      nrel <= (kind == 0) ? 2'h2 : 2'h1;
      arm <= 1'b1;
      @(posedge clock_i);
      arm <= 1'b0;
    end
    bus_wr(usb_txn_pkg::REG_CTRL, {5'h00, enc, kind != 0, 1'b1});
    capture();
    check_pkt(tb, tlen);
    if (kind == 0)
    begin
      capture();
      check_pkt(db, dlen);
      bus_wr(8'h40, ~tb[255 -: 8]);
      bus_wr(usb_txn_pkg::REG_TOKEN_LEN, 8'h55);
    end
    if (kind == 1)
    begin
      capture();
      check_pkt({ACK, 248'h0}, 8);
    end
    if (kind == 2)
      repeat (600)
      begin
        @(posedge clock_i);
        #1;
        chk("quiet", 8'h00, {4'h0, port});
      end
    wait_idle();
    rd(usb_txn_pkg::REG_STATUS, d);
    chk("status", exp_status(kind), d);
    rd(usb_txn_pkg::REG_TOKEN_LEN, d);
    chk("token_len", 8'h00, d);
    rd(usb_txn_pkg::REG_CTRL, d);
    chk("enc", {7'h00, enc}, {7'h00, d[2]});
    if (kind == 0)
    begin
      rd(usb_txn_pkg::REG_HSK_RESULT, d);
      chk("hsk", pb[255 -: 8], d);
      rd(usb_txn_pkg::REG_DATA_LEN, d);
      chk("data_len", 8'h00, d);
      rd(8'h40, d);
      chk("busy_write", tb[255 -: 8], d);
    end
    if (kind == 1)
    begin
      rd(usb_txn_pkg::REG_DATA_LEN, d);
      chk("data_len", init + 8'(plen), d);
      for (int i = 0; i < (plen + 7) / 8; i++)
      begin
        rd(8'h60 + 8'(i), d);
        m = mask(plen - 8*i);
        chk("rx_byte", pb[255 - 8*i -: 8] & m, d & m);
      end
    end
  endtask

  initial
  begin
    logic [7:0] d;
    seed = 32'h9e13;
    err_total = 0;
    num_checks = 0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    arm = 1'b0;
    gap = 8'h00;
    nbits = 8'h00;
    nrel = 2'h0;
    pbits = 256'h0;
    repeat (12) @(posedge clock_i);
    chk("reset_port", 8'h00, {4'h0, port});
    rstn_i <= 1'b1;
    rd(usb_txn_pkg::REG_STATUS, d);
    chk("reset_status", 8'h00, d);
    bus_wr(8'hFF, 8'hA5);
    rd(8'hFF, d);
    chk("unmapped", 8'h00, d);
    // A write made while the clock enable is low must be lost
    @(posedge clock_i);
    ce_i <= 1'b0;
    bus_wr(usb_txn_pkg::REG_TOKEN_LEN, 8'h33);
    ce_i <= 1'b1;
    rd(usb_txn_pkg::REG_TOKEN_LEN, d);
    chk("frozen_write", 8'h00, d);
    run_txn(0, 255);
    // Read data stand one cycle only, then fall back to zero
    rd(usb_txn_pkg::REG_STATUS, d);
    @(posedge clock_i);
    #1;
    chk("rdata_idle", 8'h00, rdata_o);
    run_txn(1, 1);
    run_txn(2, 8);
    run_txn(3, 16);
    for (int k = 0; k < 6; k++)
      run_txn(k % 3, 1 + ($random(seed) & 63));
    complete_run();
  end
endmodule

`default_nettype wire
